/* src/ratc_pkg.sv */
// Package of constants and types for the register access type cells
package ratc_pkg;

  // Field width defaults for each kind of cell
  localparam int RATC_RO_W   = 8;
  localparam int RATC_RC_W   = 8;
  localparam int RATC_WO_W   = 8;
  localparam int RATC_W1C_W  = 8;
  localparam int RATC_W0C_W  = 8;
  localparam int RATC_LL_W   = 4;
  localparam int RATC_LH_W   = 4;
  localparam int RATC_SC_W   = 4;
  localparam int RATC_RSV_W  = 8;

  // Reset values
  localparam logic RATC_RST_LOW  = 1'b0;
  localparam logic RATC_RST_HIGH = 1'b1;

  // Value shown on reads of write-only bits
  localparam logic RATC_WO_READ_VAL = 1'b0;

  // Value shown on reads of reserved bits
  localparam logic RATC_RSV_READ_VAL = 1'b0;

  // Cell kinds handled by the generic bit cell
  typedef enum logic [2:0] {
    RATC_KIND_RC,
    RATC_KIND_W1C,
    RATC_KIND_W0C,
    RATC_KIND_LL,
    RATC_KIND_LH,
    RATC_KIND_SC
  } ratc_kind_t;

endpackage

/* src/ratc_cell.sv */
// One row of register bits of a single access kind that hardware and software both touch
`timescale 1ns/1ps
`default_nettype none
module ratc_cell #(
  parameter ratc_pkg::ratc_kind_t KIND = ratc_pkg::RATC_KIND_RC,
  parameter int                   W    = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         rd_stb,
  input  wire logic         wr_stb,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] hw_event,
  output logic      [W-1:0] value
);
  import ratc_pkg::*;

  logic [W-1:0] bits_reg;
  logic [W-1:0] bits_next;
  logic [W-1:0] clr_mask;
  logic [W-1:0] set_mask;

  // Clearing term for each kind; the bit that a set term asserts wins below
  assign clr_mask =
      (KIND == RATC_KIND_RC)  ? {W{rd_stb}} :
      (KIND == RATC_KIND_W1C) ? ({W{wr_stb}} & wr_data) :
      (KIND == RATC_KIND_W0C) ? ({W{wr_stb}} & ~wr_data) :
      (KIND == RATC_KIND_LH)  ? {W{rd_stb}} :
      (KIND == RATC_KIND_LL)  ? {W{rd_stb}} :
      {W{1'b1}};

  // Setting term: an event (inverted for latch-low), or for self-clearing bits a written one
  assign set_mask =
      (KIND == RATC_KIND_SC) ? ({W{wr_stb}} & wr_data) :
      (KIND == RATC_KIND_LL) ? ~hw_event :
      hw_event;

  // Set wins over clear so an event in the clearing cycle is kept
  // For latch-low the stored bits are kept inverted (one means latched low)
  assign bits_next = (bits_reg & ~clr_mask) | set_mask;

  always_ff @(posedge clk_sys or posedge rst) begin
    // Every kind resets cleared; latch-low is stored inverted, so cleared means released
    if (rst) begin
      bits_reg <= {W{RATC_RST_LOW}};
    end else begin
      bits_reg <= bits_next;
    end
  end

  // Latch-low reads low while latched, otherwise follows its condition
  assign value = (KIND == RATC_KIND_LL) ? ~bits_reg : bits_reg;

endmodule
`default_nettype wire

/* src/ratc_bank.sv */
// Bank of register bits demonstrating each access kind behind its own read strobe, write strobe or both per field
//
// What this block does
// - Read-only bits show their source on reads and ignore all writes.
// - Read-to-clear bits show their value on a read, then clear, and ignore writes.
// - Write-only bits take writes, and their read value is meaningless.
// - Write-one-to-clear bits clear where a one is written and keep where a zero is.
// - Write-zero-to-clear bits clear where a zero is written and keep where a one is.
// - A latch-low status bit stays low after its condition drops until it is read.
// - A read releases a latch-low bit so it follows its condition again.
// - A latch-high status bit stays high after its condition rises until it is read.
// - A read releases a latch-high bit so it follows its condition again.
// - A self-clearing bit set by a write returns to zero by itself and stays readable.
// - Writing zero to a self-clearing bit does nothing and aborts nothing.
`timescale 1ns/1ps
`default_nettype none
module ratc_bank #(
  parameter int RO_W  = ratc_pkg::RATC_RO_W,
  parameter int RC_W  = ratc_pkg::RATC_RC_W,
  parameter int WO_W  = ratc_pkg::RATC_WO_W,
  parameter int W1C_W = ratc_pkg::RATC_W1C_W,
  parameter int W0C_W = ratc_pkg::RATC_W0C_W,
  parameter int LL_W  = ratc_pkg::RATC_LL_W,
  parameter int LH_W  = ratc_pkg::RATC_LH_W,
  parameter int SC_W  = ratc_pkg::RATC_SC_W,
  parameter int RSV_W = ratc_pkg::RATC_RSV_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Software side: a read strobe, a write strobe or both per field, as its access kind needs
  input  wire logic             ro_rd,
  input  wire logic             ro_wr,
  input  wire logic [RO_W-1:0]  ro_wdata,
  input  wire logic             rc_rd,
  input  wire logic             rc_wr,
  input  wire logic [RC_W-1:0]  rc_wdata,
  input  wire logic             wo_wr,
  input  wire logic [WO_W-1:0]  wo_wdata,
  input  wire logic             w1c_wr,
  input  wire logic [W1C_W-1:0] w1c_wdata,
  input  wire logic             w0c_wr,
  input  wire logic [W0C_W-1:0] w0c_wdata,
  input  wire logic             ll_rd,
  input  wire logic             lh_rd,
  input  wire logic             sc_wr,
  input  wire logic [SC_W-1:0]  sc_wdata,
  input  wire logic             rsv_wr,
  input  wire logic [RSV_W-1:0] rsv_wdata,
  // Hardware side: status and events from the same clock domain
  input  wire logic [RO_W-1:0]  ro_status,
  input  wire logic [RC_W-1:0]  rc_event,
  input  wire logic [W1C_W-1:0] w1c_event,
  input  wire logic [W0C_W-1:0] w0c_event,
  input  wire logic [LL_W-1:0]  ll_status,
  input  wire logic [LH_W-1:0]  lh_status,
  // Read data, registered except the constant write-only and reserved fields
  output logic      [RO_W-1:0]  ro_rdata,
  output logic      [RC_W-1:0]  rc_rdata,
  output logic      [WO_W-1:0]  wo_rdata,
  output logic      [W1C_W-1:0] w1c_rdata,
  output logic      [W0C_W-1:0] w0c_rdata,
  output logic      [LL_W-1:0]  ll_rdata,
  output logic      [LH_W-1:0]  lh_rdata,
  output logic      [SC_W-1:0]  sc_rdata,
  output logic      [RSV_W-1:0] rsv_rdata,
  // Hardware side: control outputs
  output logic      [WO_W-1:0]  wo_ctrl,
  output logic      [SC_W-1:0]  sc_pulse
);
  import ratc_pkg::*;

  logic [RC_W-1:0]  rc_val;
  logic [W1C_W-1:0] w1c_val;
  logic [W0C_W-1:0] w0c_val;
  logic [LL_W-1:0]  ll_val;
  logic [LH_W-1:0]  lh_val;
  logic [SC_W-1:0]  sc_val;
  logic [RO_W-1:0]  ro_rdata_reg;
  logic [RC_W-1:0]  rc_rdata_reg;
  logic [W1C_W-1:0] w1c_rdata_reg;
  logic [W0C_W-1:0] w0c_rdata_reg;
  logic [LL_W-1:0]  ll_rdata_reg;
  logic [LH_W-1:0]  lh_rdata_reg;
  logic [SC_W-1:0]  sc_rdata_reg;
  logic [WO_W-1:0]  wo_ctrl_reg;
  logic [RO_W-1:0]  ro_rdata_next;
  logic [RC_W-1:0]  rc_rdata_next;
  logic [LL_W-1:0]  ll_rdata_next;
  logic [LH_W-1:0]  lh_rdata_next;
  logic [WO_W-1:0]  wo_ctrl_next;
  logic             unused_wr;

  // Writes to read-only, read-to-clear and reserved fields are dropped
  // Nothing stores them, so a stray write can never leak back on a read
  assign unused_wr = ro_wr ^ (^ro_wdata) ^ rc_wr ^ (^rc_wdata)
                   ^ rsv_wr ^ (^rsv_wdata);

  ratc_cell #(.KIND(RATC_KIND_RC), .W(RC_W)) u_rc (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rd_stb   (rc_rd),
    .wr_stb   (1'b0),
    .wr_data  ('0),
    .hw_event (rc_event),
    .value    (rc_val)
  );

  ratc_cell #(.KIND(RATC_KIND_W1C), .W(W1C_W)) u_w1c (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rd_stb   (1'b0),
    .wr_stb   (w1c_wr),
    .wr_data  (w1c_wdata),
    .hw_event (w1c_event),
    .value    (w1c_val)
  );

  ratc_cell #(.KIND(RATC_KIND_W0C), .W(W0C_W)) u_w0c (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rd_stb   (1'b0),
    .wr_stb   (w0c_wr),
    .wr_data  (w0c_wdata),
    .hw_event (w0c_event),
    .value    (w0c_val)
  );

  ratc_cell #(.KIND(RATC_KIND_LL), .W(LL_W)) u_ll (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rd_stb   (ll_rd),
    .wr_stb   (1'b0),
    .wr_data  ('0),
    .hw_event (ll_status),
    .value    (ll_val)
  );

  ratc_cell #(.KIND(RATC_KIND_LH), .W(LH_W)) u_lh (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rd_stb   (lh_rd),
    .wr_stb   (1'b0),
    .wr_data  ('0),
    .hw_event (lh_status),
    .value    (lh_val)
  );

  ratc_cell #(.KIND(RATC_KIND_SC), .W(SC_W)) u_sc (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rd_stb   (1'b0),
    .wr_stb   (sc_wr),
    .wr_data  (sc_wdata),
    .hw_event ('0),
    .value    (sc_val)
  );

  // Capture selection: a strobe loads the pre-clear value, otherwise hold
  // Taking the value before the edge means the clear cannot hide what was read
  assign ro_rdata_next = ro_rd ? ro_status : ro_rdata_reg;
  assign rc_rdata_next = rc_rd ? rc_val : rc_rdata_reg;
  assign ll_rdata_next = ll_rd ? ll_val : ll_rdata_reg;
  assign lh_rdata_next = lh_rd ? lh_val : lh_rdata_reg;
  assign wo_ctrl_next  = wo_wr ? wo_wdata : wo_ctrl_reg;

  // Read data is captured on the read strobe so the value returned is the
  // one before the clear; it then holds until the next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ro_rdata_reg  <= '0;
      rc_rdata_reg  <= '0;
      ll_rdata_reg  <= '0;
      lh_rdata_reg  <= '0;
    end else begin
      ro_rdata_reg  <= ro_rdata_next;
      rc_rdata_reg  <= rc_rdata_next;
      ll_rdata_reg  <= ll_rdata_next;
      lh_rdata_reg  <= lh_rdata_next;
    end
  end

  // Write-clear and self-clearing fields are sampled every cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      w1c_rdata_reg <= '0;
      w0c_rdata_reg <= '0;
      sc_rdata_reg  <= '0;
    end else begin
      w1c_rdata_reg <= w1c_val;
      w0c_rdata_reg <= w0c_val;
      sc_rdata_reg  <= sc_val;
    end
  end

  // Write-only control is stored but never returned
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wo_ctrl_reg <= '0;
    end else begin
      wo_ctrl_reg <= wo_ctrl_next;
    end
  end

  assign ro_rdata  = ro_rdata_reg;
  assign rc_rdata  = rc_rdata_reg;
  assign wo_rdata  = {WO_W{RATC_WO_READ_VAL}};
  assign w1c_rdata = w1c_rdata_reg;
  assign w0c_rdata = w0c_rdata_reg;
  assign ll_rdata  = ll_rdata_reg;
  assign lh_rdata  = lh_rdata_reg;
  assign sc_rdata  = sc_rdata_reg;
  assign rsv_rdata = {RSV_W{RATC_RSV_READ_VAL}};
  assign wo_ctrl   = wo_ctrl_reg;
  // Self-clearing bits act as a one-cycle start pulse
  // A zero written meanwhile cannot cut it short: writes only ever set the cell
  assign sc_pulse  = sc_val;

endmodule
`default_nettype wire

/* dv/ratc_bank_sva.sv */
// Concurrent checks of the register access bank, bound onto its ports
`timescale 1ns/1ps
`default_nettype none
module ratc_bank_sva (
  input wire logic                            clk_sys,
  input wire logic                            rst,
  input wire logic                            ro_rd,
  input wire logic                            rc_rd,
  input wire logic                            wo_wr,
  input wire logic                            w1c_wr,
  input wire logic                            w0c_wr,
  input wire logic                            ll_rd,
  input wire logic                            lh_rd,
  input wire logic                            sc_wr,
  input wire logic [ratc_pkg::RATC_RO_W-1:0]  ro_status,
  input wire logic [ratc_pkg::RATC_RO_W-1:0]  ro_rdata,
  input wire logic [ratc_pkg::RATC_RC_W-1:0]  rc_event,
  input wire logic [ratc_pkg::RATC_RC_W-1:0]  rc_rdata,
  input wire logic [ratc_pkg::RATC_WO_W-1:0]  wo_wdata,
  input wire logic [ratc_pkg::RATC_WO_W-1:0]  wo_ctrl,
  input wire logic [ratc_pkg::RATC_W1C_W-1:0] w1c_wdata,
  input wire logic [ratc_pkg::RATC_W1C_W-1:0] w1c_event,
  input wire logic [ratc_pkg::RATC_W1C_W-1:0] w1c_rdata,
  input wire logic [ratc_pkg::RATC_W0C_W-1:0] w0c_wdata,
  input wire logic [ratc_pkg::RATC_W0C_W-1:0] w0c_event,
  input wire logic [ratc_pkg::RATC_W0C_W-1:0] w0c_rdata,
  input wire logic [ratc_pkg::RATC_LL_W-1:0]  ll_status,
  input wire logic [ratc_pkg::RATC_LL_W-1:0]  ll_rdata,
  input wire logic [ratc_pkg::RATC_LH_W-1:0]  lh_status,
  input wire logic [ratc_pkg::RATC_LH_W-1:0]  lh_rdata,
  input wire logic [ratc_pkg::RATC_SC_W-1:0]  sc_wdata,
  input wire logic [ratc_pkg::RATC_SC_W-1:0]  sc_pulse
);
  import ratc_pkg::*;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Back-to-back reads expose what the first read left behind
  sequence s_rc2;
    rc_rd ##1 rc_rd;
  endsequence
  sequence s_ll2;
    ll_rd ##1 ll_rd;
  endsequence
  sequence s_lh2;
    lh_rd ##1 lh_rd;
  endsequence
  property p_ro;
    ro_rd |=> ro_rdata == $past(ro_status);
  endproperty
  a_ro: assert property (p_ro) else $error("read-only capture wrong");
  property p_rc;
    s_rc2 |=> rc_rdata == $past(rc_event, 2);
  endproperty
  a_rc: assert property (p_rc) else $error("read-to-clear did not clear");
  property p_wo;
    wo_wr |=> wo_ctrl == $past(wo_wdata);
  endproperty
  a_wo: assert property (p_wo) else $error("write-only value not taken");
  property p_w1c;
    w1c_wr |-> ##2 (w1c_rdata & $past(w1c_wdata, 2) & ~$past(w1c_event, 2)) == '0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one clear failed");
  property p_w0c;
    w0c_wr |-> ##2 (w0c_rdata & ~$past(w0c_wdata, 2) & ~$past(w0c_event, 2)) == '0;
  endproperty
  a_w0c: assert property (p_w0c) else $error("write-zero clear failed");
  property p_ll;
    s_ll2 |=> (ll_rdata | $past(ll_status, 2)) == $past(ll_status, 2);
  endproperty
  a_ll: assert property (p_ll) else $error("latch-low lost a low");
  property p_lh;
    s_lh2 |=> (lh_rdata & $past(lh_status, 2)) == $past(lh_status, 2);
  endproperty
  a_lh: assert property (p_lh) else $error("latch-high lost a high");
  property p_sc;
    sc_wr |=> sc_pulse == $past(sc_wdata) ##1 ($past(sc_wr) || sc_pulse == '0);
  endproperty
  a_sc: assert property (p_sc) else $error("self-clearing pulse wrong");
endmodule
bind ratc_bank ratc_bank_sva u_ratc_bank_sva (
  .clk_sys   (clk_sys),
  .rst       (rst),
  .ro_rd     (ro_rd),
  .rc_rd     (rc_rd),
  .wo_wr     (wo_wr),
  .w1c_wr    (w1c_wr),
  .w0c_wr    (w0c_wr),
  .ll_rd     (ll_rd),
  .lh_rd     (lh_rd),
  .sc_wr     (sc_wr),
  .ro_status (ro_status),
  .ro_rdata  (ro_rdata),
  .rc_event  (rc_event),
  .rc_rdata  (rc_rdata),
  .wo_wdata  (wo_wdata),
  .wo_ctrl   (wo_ctrl),
  .w1c_wdata (w1c_wdata),
  .w1c_event (w1c_event),
  .w1c_rdata (w1c_rdata),
  .w0c_wdata (w0c_wdata),
  .w0c_event (w0c_event),
  .w0c_rdata (w0c_rdata),
  .ll_status (ll_status),
  .ll_rdata  (ll_rdata),
  .lh_status (lh_status),
  .lh_rdata  (lh_rdata),
  .sc_wdata  (sc_wdata),
  .sc_pulse  (sc_pulse)
);
`default_nettype wire

/* dv/tb_top.sv */
// Random traffic on every access kind, compared with a bit model each cycle
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ratc_pkg::*;
  logic clk_sys, rst, ro_rd, ro_wr, rc_rd, rc_wr, wo_wr, w1c_wr, w0c_wr;
  logic ll_rd, lh_rd, sc_wr, rsv_wr;
  logic [7:0] ro_wdata, rc_wdata, wo_wdata, w1c_wdata, w0c_wdata, rsv_wdata;
  logic [7:0] ro_status, rc_event, w1c_event, w0c_event, wo_ctrl;
  logic [7:0] ro_rdata, rc_rdata, wo_rdata, w1c_rdata, w0c_rdata, rsv_rdata;
  logic [3:0] ll_status, lh_status, sc_wdata, ll_rdata, lh_rdata, sc_rdata, sc_pulse;
  logic [7:0] m_ro, m_rc, c_rc, m_w1, c_w1, m_w0, c_w0, m_wo;
  logic [3:0] m_ll, c_ll, m_lh, c_lh, m_sc, c_sc;
  logic [31:0] seed = 32'hbc4712a2;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  ratc_bank u_ratc_bank (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ro_rd     (ro_rd),
    .ro_wr     (ro_wr),
    .ro_wdata  (ro_wdata),
    .rc_rd     (rc_rd),
    .rc_wr     (rc_wr),
    .rc_wdata  (rc_wdata),
    .wo_wr     (wo_wr),
    .wo_wdata  (wo_wdata),
    .w1c_wr    (w1c_wr),
    .w1c_wdata (w1c_wdata),
    .w0c_wr    (w0c_wr),
    .w0c_wdata (w0c_wdata),
    .ll_rd     (ll_rd),
    .lh_rd     (lh_rd),
    .sc_wr     (sc_wr),
    .sc_wdata  (sc_wdata),
    .rsv_wr    (rsv_wr),
    .rsv_wdata (rsv_wdata),
    .ro_status (ro_status),
    .rc_event  (rc_event),
    .w1c_event (w1c_event),
    .w0c_event (w0c_event),
    .ll_status (ll_status),
    .lh_status (lh_status),
    .ro_rdata  (ro_rdata),
    .rc_rdata  (rc_rdata),
    .wo_rdata  (wo_rdata),
    .w1c_rdata (w1c_rdata),
    .w0c_rdata (w0c_rdata),
    .ll_rdata  (ll_rdata),
    .lh_rdata  (lh_rdata),
    .sc_rdata  (sc_rdata),
    .rsv_rdata (rsv_rdata),
    .wo_ctrl   (wo_ctrl),
    .sc_pulse  (sc_pulse)
  );
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    {ro_rd, ro_wr, rc_rd, rc_wr, wo_wr, w1c_wr, w0c_wr, ll_rd, lh_rd, sc_wr, rsv_wr} = '0;
    {ro_wdata, rc_wdata, wo_wdata, w1c_wdata, w0c_wdata, rsv_wdata, sc_wdata} = '0;
    {ro_status, rc_event, w1c_event, w0c_event, ll_status, lh_status} = '0;
    {m_ro, m_rc, c_rc, m_w1, c_w1, m_w0, c_w0, m_wo, m_ll, m_lh, c_lh, m_sc, c_sc} = '0;
    // Latch-low starts released, so it follows its condition
    c_ll = 4'hf;
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2000) begin
      chk("ro_rdata", ro_rdata, m_ro);
      chk("rc_rdata", rc_rdata, m_rc);
      chk("wo_ctrl", wo_ctrl, m_wo);
      chk("wo_rdata", wo_rdata, {8{RATC_WO_READ_VAL}});
      chk("w1c_rdata", w1c_rdata, m_w1);
      chk("w0c_rdata", w0c_rdata, m_w0);
      chk("ll_rdata", {4'h0, ll_rdata}, {4'h0, m_ll});
      chk("lh_rdata", {4'h0, lh_rdata}, {4'h0, m_lh});
      chk("sc_pulse", {4'h0, sc_pulse}, {4'h0, c_sc});
      chk("sc_rdata", {4'h0, sc_rdata}, {4'h0, m_sc});
      chk("rsv_rdata", rsv_rdata, {8{RATC_RSV_READ_VAL}});
      seed = xs(seed);
      {ro_rd, ro_wr, rc_rd, rc_wr, wo_wr, w1c_wr, w0c_wr, sc_wr, rsv_wr, ll_rd, lh_rd} = seed[10:0];
      {ro_status, rc_event} = {seed[18:11], seed[26:19] & seed[31:24]};
      // Status may move on a read cycle too, so a release and a new latch meet
      ll_status = seed[14:11] | seed[30:27];
      lh_status = seed[22:19] & seed[28:25];
      seed = xs(seed);
      {ro_wdata, rc_wdata, wo_wdata, w1c_wdata} = seed;
      seed = xs(seed);
      {w0c_wdata, w1c_event, w0c_event} = {seed[31:24], seed[15:8], seed[7:0] & seed[15:8]};
      rsv_wdata = 8'h00;
      sc_wdata = seed[27:24];
      if (ro_rd) m_ro = ro_status;
      if (rc_rd) m_rc = c_rc;
      c_rc = (rc_rd ? 8'h00 : c_rc) | rc_event;
      if (wo_wr) m_wo = wo_wdata;
      m_w1 = c_w1;
      c_w1 = (w1c_wr ? c_w1 & ~w1c_wdata : c_w1) | w1c_event;
      m_w0 = c_w0;
      c_w0 = (w0c_wr ? c_w0 & w0c_wdata : c_w0) | w0c_event;
      if (ll_rd) m_ll = c_ll;
      c_ll = ll_rd ? ll_status : c_ll & ll_status;
      if (lh_rd) m_lh = c_lh;
      c_lh = lh_rd ? lh_status : c_lh | lh_status;
      m_sc = c_sc;
      c_sc = sc_wr ? sc_wdata : 4'h0;
      @(negedge clk_sys);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
